/* agcctl_regs.svh */
`ifndef AGCCTL_REGS_SVH
`define AGCCTL_REGS_SVH

// ********************************************************
// Register offsets
// ********************************************************
`define AGCCTL_ADDR_W 8
`define AGCCTL_OFS_LEFT_GAIN 8'h5D
`define AGCCTL_OFS_ENABLE_TARGET 8'h5E
`define AGCCTL_OFS_HYST_NOISE 8'h5F
`define AGCCTL_OFS_MAX_GAIN 8'h60
`define AGCCTL_OFS_RIGHT_GAIN 8'h70

// ********************************************************
// Field positions
// ********************************************************
`define AGCCTL_EN_BIT 7
`define AGCCTL_TARGET_MSB 6
`define AGCCTL_TARGET_LSB 4
`define AGCCTL_GHYST_MSB 1
`define AGCCTL_GHYST_LSB 0
`define AGCCTL_LHYST_MSB 7
`define AGCCTL_LHYST_LSB 6
`define AGCCTL_NOISE_MSB 5
`define AGCCTL_NOISE_LSB 1
`define AGCCTL_MAXG_MSB 6
`define AGCCTL_MAXG_LSB 0

// ********************************************************
// Reset values and limits, gain in 0.5 dB steps
// ********************************************************
`define AGCCTL_RST_GAIN 8'h00
`define AGCCTL_RST_MAXG 7'h7F
`define AGCCTL_MAXG_CLAMP 7'h74
`define AGCCTL_GAIN_MIN 8'hF4
`define AGCCTL_NOISE_BASE 10'h3C4
`define AGCCTL_NOISE_STEP 10'h004

`endif

/* agcctl_pkg.sv */
package agcctl_pkg;

    // Direction of the last gain step, for gain hysteresis
    typedef enum logic [1:0] {
        DIR_NONE = 2'b00,
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } agcctl_dir_t;

    typedef struct packed {
        logic enable;
        logic [2:0] target;
        logic [1:0] gainHyst;
        logic [1:0] levelHyst;
        logic [4:0] noiseThr;
        logic [6:0] maxGain;
        logic [7:0] gain;
        agcctl_dir_t lastDir;
        logic [7:0] rdData;
    } agcctl_state_t;

endpackage

/* audio_agc_control.sv */
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "agcctl_regs.svh"

// Operation
// (R1) Left AGC gain readback: read-only signed 0.5 dB code, resets to zero.
// (R2) Enable bit 7 turns right AGC on; resets off.
// (R3) Bits 6:4 pick target -5.5 to -24 dBFS.
// (R4) Bits 1:0 gain hysteresis: off, 0.5, 1.0, 1.5 dB.
// (R5) Second register bits 7:6 level hysteresis: 1, 2, 4 dB, or off.
// (R6) Bits 5:1 noise gate: zero off, else -30 to -90 dB by 2 dB.
// (R7) Seven-bit maximum gain, 0.5 dB steps, clamps at 58 dB, resets all ones.
// (R8) Reserved bits are read-only and read zero; writes ignored.
// (R9) Enabled AGC steers gain to target, within max, hold inside band.
module audio_agc_control (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [`AGCCTL_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic [7:0] leftGain,
    input wire logic levelStb,
    input wire logic [7:0] rightLevel,
    output logic [7:0] rightGain,
    output logic rightAgcOn
);
    import agcctl_pkg::*;

    // ********************************************************
    // Helpers, all levels in signed 0.5 dB units
    // ********************************************************
    function automatic logic signed [9:0] targetLevel(input logic [2:0] c);
        unique case (c)
            3'h0: targetLevel = -10'sd11;
            3'h1: targetLevel = -10'sd16;
            3'h2: targetLevel = -10'sd20;
            3'h3: targetLevel = -10'sd24;
            3'h4: targetLevel = -10'sd28;
            3'h5: targetLevel = -10'sd34;
            3'h6: targetLevel = -10'sd40;
            3'h7: targetLevel = -10'sd48;
        endcase
    endfunction

    function automatic logic signed [9:0] levelBand(input logic [1:0] c);
        unique case (c)
            2'h0: levelBand = 10'sd2;
            2'h1: levelBand = 10'sd4;
            2'h2: levelBand = 10'sd8;
            2'h3: levelBand = 10'sd0;
        endcase
    endfunction

    function automatic logic signed [9:0] ext8(input logic [7:0] v);
        ext8 = signed'({{2{v[7]}}, v});
    endfunction

    // ********************************************************
    // Gain arithmetic
    // ********************************************************
    // Codes above 58 dB all act as 58 dB
    function automatic logic signed [9:0] maxLimit(input logic [6:0] c);
        if (c > `AGCCTL_MAXG_CLAMP) begin
            maxLimit = signed'({3'b000, `AGCCTL_MAXG_CLAMP});
        end else begin
            maxLimit = signed'({3'b000, c});
        end
    endfunction

    // Extra margin to reverse direction, one code per 0.5 dB
    function automatic logic signed [9:0] hystMargin(input logic [1:0] c);
        hystMargin = signed'({8'h00, c});
    endfunction

    // Threshold falls 2 dB per code; code zero never reaches the compare
    function automatic logic signed [9:0] gateLevel(input logic [4:0] c);
        gateLevel = signed'(`AGCCTL_NOISE_BASE) -
            signed'(`AGCCTL_NOISE_STEP) * (signed'({5'h00, c}) - 10'sd1);
    endfunction

    // Callers keep the result inside the floor and the ceiling
    function automatic logic [7:0] stepGain(input logic signed [9:0] g,
            input logic up);
        if (up) begin
            stepGain = 8'(g + 10'sd1);
        end else begin
            stepGain = 8'(g - 10'sd1);
        end
    endfunction

    agcctl_state_t cur_r;
    agcctl_state_t cur_nxt;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        logic signed [9:0] err;
        logic signed [9:0] upThr;
        logic signed [9:0] dnThr;
        logic signed [9:0] gainS;
        logic signed [9:0] maxS;
        logic signed [9:0] inLevel;
        logic signed [9:0] gateLvl;
        logic gated;
        err = '0;
        upThr = '0;
        dnThr = '0;
        gainS = ext8(cur_r.gain);
        maxS = '0;
        inLevel = '0;
        gateLvl = '0;
        gated = 1'b0;
        cur_nxt = cur_r;

        // Register writes; reserved positions are never stored
        if (regWrEn) begin
            unique case (regAddr)
                `AGCCTL_OFS_ENABLE_TARGET: begin
                    cur_nxt.enable = regWrData[`AGCCTL_EN_BIT]; // (R2)
                    cur_nxt.target =
                        regWrData[`AGCCTL_TARGET_MSB:`AGCCTL_TARGET_LSB]; // (R3)
                    cur_nxt.gainHyst =
                        regWrData[`AGCCTL_GHYST_MSB:`AGCCTL_GHYST_LSB]; // (R4)
                end
                `AGCCTL_OFS_HYST_NOISE: begin
                    cur_nxt.levelHyst =
                        regWrData[`AGCCTL_LHYST_MSB:`AGCCTL_LHYST_LSB]; // (R5)
                    cur_nxt.noiseThr =
                        regWrData[`AGCCTL_NOISE_MSB:`AGCCTL_NOISE_LSB]; // (R6)
                end
                `AGCCTL_OFS_MAX_GAIN: begin
                    cur_nxt.maxGain =
                        regWrData[`AGCCTL_MAXG_MSB:`AGCCTL_MAXG_LSB]; // (R7)
                end
                default: begin
                end
            endcase
        end

        // Register reads, data valid the following cycle only
        cur_nxt.rdData = 8'h00;
        if (regRdEn) begin
            unique case (regAddr)
                `AGCCTL_OFS_LEFT_GAIN: cur_nxt.rdData = leftGain; // (R1)
                `AGCCTL_OFS_ENABLE_TARGET:
                    cur_nxt.rdData = {cur_r.enable, cur_r.target, 2'b00,
                        cur_r.gainHyst}; // (R8)
                `AGCCTL_OFS_HYST_NOISE:
                    cur_nxt.rdData = {cur_r.levelHyst, cur_r.noiseThr,
                        1'b0}; // (R8)
                `AGCCTL_OFS_MAX_GAIN:
                    cur_nxt.rdData = {1'b0, cur_r.maxGain}; // (R8)
                `AGCCTL_OFS_RIGHT_GAIN: cur_nxt.rdData = cur_r.gain;
                default: cur_nxt.rdData = 8'h00;
            endcase
        end

        maxS = maxLimit(cur_r.maxGain); // (R7)

        // Gain loop, one 0.5 dB step per level sample, or per cycle while gain is above the max
        if (!cur_r.enable) begin
            // Disabled channel sits at unity gain
            cur_nxt.gain = `AGCCTL_RST_GAIN; // (R2)
            cur_nxt.lastDir = DIR_NONE;
        end else if (gainS > maxS) begin
            // Max lowered under the running gain: walk down at once
            cur_nxt.gain = stepGain(gainS, 1'b0); // (R7)
            cur_nxt.lastDir = DIR_DOWN;
        end else if (levelStb) begin
            err = ext8(rightLevel) - targetLevel(cur_r.target); // (R3)
            upThr = levelBand(cur_r.levelHyst); // (R5)
            dnThr = levelBand(cur_r.levelHyst); // (R5)
            // Reversing direction needs the extra gain hysteresis
            if (cur_r.lastDir == DIR_DOWN) begin
                upThr = upThr + hystMargin(cur_r.gainHyst); // (R4)
            end
            if (cur_r.lastDir == DIR_UP) begin
                dnThr = dnThr + hystMargin(cur_r.gainHyst); // (R4)
            end
            // Gate compares the level before our gain was applied
            inLevel = ext8(rightLevel) - gainS;
            gateLvl = gateLevel(cur_r.noiseThr); // (R6)
            gated = (cur_r.noiseThr != 5'h00) && (inLevel < gateLvl); // (R6)
            if (err > dnThr) begin
                if (gainS > ext8(`AGCCTL_GAIN_MIN)) begin
                    cur_nxt.gain = stepGain(gainS, 1'b0); // (R9)
                    cur_nxt.lastDir = DIR_DOWN;
                end
            end else if ((err < -upThr) && !gated) begin
                // Noise held below the gate must not be boosted
                if (gainS < maxS) begin
                    cur_nxt.gain = stepGain(gainS, 1'b1); // (R9)
                    cur_nxt.lastDir = DIR_UP;
                end
            end
        end
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur_r.enable <= 1'b0; // (R2)
            cur_r.target <= 3'h0;
            cur_r.gainHyst <= 2'h0;
            cur_r.levelHyst <= 2'h0;
            cur_r.noiseThr <= 5'h00;
            cur_r.maxGain <= `AGCCTL_RST_MAXG; // (R7)
            // Unity gain, so a later enable never starts with a jump
            cur_r.gain <= `AGCCTL_RST_GAIN;
            cur_r.lastDir <= DIR_NONE;
            cur_r.rdData <= 8'h00;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign regRdData = cur_r.rdData;
    assign rightGain = cur_r.gain;
    assign rightAgcOn = cur_r.enable;

endmodule

/* agcctl_monitor.sv */
`timescale 1ns/10ps
`include "agcctl_regs.svh"
// ********
// Checks
// ********
module agcctl_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [`AGCCTL_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic [7:0] leftGain,
    input wire logic levelStb,
    input wire logic [7:0] rightLevel,
    input wire logic [7:0] rightGain,
    input wire logic rightAgcOn
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    AST_RD_IDLE: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
        else $error("read data outside slot");
    AST_LEFT_RD: assert property (regRdEn && regAddr == 8'h5D |=>
        regRdData == $past(leftGain)) else $error("left gain readback");
    AST_EN_SET: assert property (regWrEn && regAddr == 8'h5E
        && regWrData[7] |=> rightAgcOn) else $error("enable not set");
    AST_EN_CLR: assert property (regWrEn && regAddr == 8'h5E
        && !regWrData[7] |=> !rightAgcOn) else $error("enable not clear");
    AST_RSV_5E: assert property (regRdEn && regAddr == 8'h5E |=>
        regRdData[3:2] == 2'b00) else $error("reserved bits 5E");
    AST_RSV_5F: assert property (regRdEn && regAddr == 8'h5F |=>
        !regRdData[0]) else $error("reserved bit 5F");
    AST_RSV_60: assert property (regRdEn && regAddr == 8'h60 |=>
        !regRdData[7]) else $error("reserved bit 60");
    AST_OFF_ZERO: assert property (!rightAgcOn [*2] |->
        rightGain == 8'h00) else $error("gain moved while off");
    AST_ONE_STEP: assert property (rightAgcOn && $past(rightAgcOn)
        && rightGain != $past(rightGain) |->
        rightGain - $past(rightGain) == 8'h01 ||
        rightGain - $past(rightGain) == 8'hFF) else $error("gain jump");
    // Without a strobe only the max-gain pull-down may move the gain
    AST_NO_STRB: assert property (rightAgcOn && !$past(levelStb)
        && rightGain != $past(rightGain) |->
        $signed(rightGain) < $signed($past(rightGain)))
        else $error("gain rose without strobe");
endmodule

/* agcctl_tb.sv */
`timescale 1ns/10ps
// ********
// Bench
// ********
module testbench;
    logic core_clk = 0, nrst = 0, regWrEn = 0, regRdEn = 0, levelStb = 0;
    logic [7:0] regAddr = 0, regWrData = 0, leftGain = 0, rightLevel = 0;
    logic [7:0] regRdData, rightGain, d;
    logic rightAgcOn;
    int errors = 0, n_checks = 0, cyc = 0, seed = 38;
    always #5 core_clk = ~core_clk;
    audio_agc_control u_dut (.core_clk, .nrst, .regAddr, .regWrData,
        .regWrEn, .regRdEn, .regRdData, .leftGain, .levelStb, .rightLevel,
        .rightGain, .rightAgcOn);
    task automatic chk(string s, logic [7:0] e, logic [7:0] v);
        n_checks++;
        if (v !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", s, e, v);
        end
    endtask
    // Reserved positions always read back as zero
    function automatic logic [7:0] rdExp(logic [7:0] a, logic [7:0] v);
        case (a)
            8'h5E: rdExp = v & 8'hF3;
            8'h5F: rdExp = v & 8'hFE;
            8'h60: rdExp = v & 8'h7F;
            default: rdExp = 8'h00;
        endcase
    endfunction
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge core_clk);
        regWrEn <= 1;
        regAddr <= a;
        regWrData <= v;
        @(posedge core_clk);
        regWrEn <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge core_clk);
        regRdEn <= 1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 0;
        #1 chk("rdata", e, regRdData);
    endtask
    // Strobes back to back, the hardest spacing allowed
    task automatic stb(logic [7:0] l, int n);
        repeat (n) begin
            @(posedge core_clk);
            levelStb <= 1;
            rightLevel <= l;
        end
        @(posedge core_clk);
        levelStb <= 0;
        #1;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            results;
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1;
        rd(8'h5E, 8'h00);
        rd(8'h5F, 8'h00);
        rd(8'h60, 8'h7F);
        @(posedge core_clk);
        leftGain <= 8'hF4;
        wr(8'h5D, 8'h11);
        rd(8'h5D, 8'hF4);
        rd(8'h61, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            d = 8'($random(seed));
            d[6:4] = i[2:0];
            d[1:0] = i[4:3];
            d = d & 8'hF3;
            wr(8'h5E, d);
            rd(8'h5E, rdExp(8'h5E, d));
            chk("enable", {7'h00, d[7]}, {7'h00, rightAgcOn});
            d = 8'($random(seed));
            d[5:1] = i[4:0];
            d[7:6] = i[1:0];
            d = d & 8'hFE;
            wr(8'h5F, d);
            rd(8'h5F, rdExp(8'h5F, d));
            d = 8'($random(seed)) & 8'h7F;
            wr(8'h60, d);
            rd(8'h60, rdExp(8'h60, d));
            d = 8'($random(seed));
            @(posedge core_clk);
            leftGain <= d;
            rd(8'h5D, d);
        end
        $display("test regs done");
        wr(8'h5F, 8'hC0);
        wr(8'h60, 8'h7F);
        wr(8'h5E, 8'h80);
        stb(8'h80, 125);
        chk("max clamp", 8'h74, rightGain);
        wr(8'h60, 8'h02);
        repeat (120) @(posedge core_clk);
        #1 chk("max lower", 8'h02, rightGain);
        stb(8'h00, 40);
        chk("floor", 8'hF4, rightGain);
        wr(8'h5F, 8'h00);
        stb(8'hF3, 5);
        chk("band hold", 8'hF4, rightGain);
        stb(8'hF2, 1);
        chk("band edge", 8'hF5, rightGain);
        rd(8'h70, 8'hF5);
        wr(8'h5E, 8'h83);
        stb(8'hFA, 3);
        chk("gain hyst", 8'hF5, rightGain);
        stb(8'hFB, 1);
        chk("gain hyst", 8'hF4, rightGain);
        wr(8'h5F, 8'h02);
        stb(8'h80, 3);
        chk("gate", 8'hF4, rightGain);
        stb(8'hD8, 1);
        chk("gate", 8'hF5, rightGain);
        @(posedge core_clk);
        nrst <= 0;
        @(posedge core_clk);
        #1 chk("reset gain", 8'h00, rightGain);
        chk("reset on", 8'h00, {7'h00, rightAgcOn});
        chk("reset rdata", 8'h00, regRdData);
        @(posedge core_clk);
        nrst <= 1;
        rd(8'h5F, 8'h00);
        rd(8'h60, 8'h7F);
        wr(8'h5E, 8'h80);
        stb(8'hD8, 1);
        chk("restart", 8'h01, rightGain);
        wr(8'h5E, 8'h00);
        repeat (2) @(posedge core_clk);
        #1 chk("off gain", 8'h00, rightGain);
        $display("test gain done");
        results;
    end
endmodule
bind audio_agc_control agcctl_monitor u_mon (.core_clk, .nrst, .regAddr,
    .regWrData, .regWrEn, .regRdEn, .regRdData, .leftGain, .levelStb,
    .rightLevel, .rightGain, .rightAgcOn);
